// File: irq_controller.sv
// Purpose: interrupt request controller for an 8-bit core
// Assumes: one clock; mc_tick marks machine cycles; insn_end marks the
//   last clock of each instruction
// Notes: acknowledge issues a registered call request with its vector
// Function
// - eleven sources, each on one of four levels
// - five sources come from peripheral logic
// - accepted request calls its fixed vector
// - service preempted only by strictly higher level
// - return ends service, resumes interrupted code
// - flags set even when source disabled
// - flags sampled once per machine cycle, then polled
// - acknowledge at next instruction by forced call
// - no acknowledge while equal or higher active
// - no acknowledge on return or enable/priority write
// - global enable bit blocks every interrupt
// - primary enable bits for five core sources
// - peripheral enables for sources two to six
// - peripheral lines combined into sources two-six
// - serial channel 1 enable bit
// - timer control register holds four flags
// - type bits pick low level or falling edge
// - polarity bits pick edge for sources 2,3
// - timer flags cleared when routine called
// - request register holds source 2-6 flags
// - source 0-6 flags cleared on vectoring
// - two priority bits give group level
`timescale 1ns/10ps
module irq_controller
  import irq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  output logic [7:0] sfr_rdata,
  // core sequencer
  input wire logic mc_tick,
  input wire logic insn_end,
  input wire logic insn_is_reti,
  output logic call_req,
  output logic [15:0] call_vector,
  output logic [3:0] call_source,
  output logic timer0_ack,
  output logic timer1_ack,
  output logic [3:0] service_active,
  // request sources
  input wire logic ext0_pin_n,
  input wire logic ext1_pin_n,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic serial0_req,
  input wire logic serial1_req,
  input wire periph_req_t periph
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0] timer_ctrl_reg;
  logic [7:0] primary_en_reg;
  logic [7:0] periph_en_reg;
  logic [7:0] ser1_en_reg;
  logic [7:0] edge_pol_reg;
  logic [7:0] ext_req_reg;
  logic [7:0] prio_low_reg;
  logic [7:0] prio_high_reg;
  logic [1:0] ext0_sync_reg;
  logic [1:0] ext1_sync_reg;
  logic [6:0] cond_prev_reg;
  logic [NUM_SRC-1:0] pend_reg;
  logic [NUM_LEVEL-1:0] in_service_reg;
  logic write_seen_reg;
  logic [7:0] rdata_reg;
  logic call_reg;
  logic [15:0] vector_reg;
  logic [3:0] source_reg;
  logic t0_ack_reg;
  logic t1_ack_reg;

  logic [6:0] cond;
  logic [6:0] rise;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] enables;
  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0] ack_vec;
  logic [1:0] src_lvl [NUM_SRC];
  logic win_valid;
  logic [3:0] win_src;
  logic [1:0] win_lvl;
  logic blk_write;
  logic nest_ok;
  logic take;
  logic [3:0] top_mask;
  logic x0_set;
  logic x1_set;
  logic global_en;

  // ----------------------------------------------------------------------
  // pin synchronisers and source conditioning
  // ----------------------------------------------------------------------
  // external pins come from outside the clock domain
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext0_sync_reg <= 2'h3;
      ext1_sync_reg <= 2'h3;
    end
    else
    begin
      ext0_sync_reg <= {ext0_sync_reg[0], ext0_pin_n};
      ext1_sync_reg <= {ext1_sync_reg[0], ext1_pin_n};
    end
  end

  // each line mapped so that its active edge is a rise; line 4 takes both edges
  always_comb
  begin
    cond[0] = ~ext0_sync_reg[1];
    cond[1] = ~ext1_sync_reg[1];
    // source 2 merges collisions and serial port
    cond[2] = (periph.flash_collision_a | periph.flash_collision_b |
      periph.spi_req) ^ ~edge_pol_reg[SRC2_POL_BIT];
    cond[3] = periph.compute_busy ^ ~edge_pol_reg[SRC3_POL_BIT];
    cond[4] = periph.pll_lock; // either edge
    cond[5] = ~periph.eeprom_busy; // falling edge
    cond[6] = ~(periph.transfer_pending | periph.clock_one_second_tick |
      periph.watchdog_near_overflow);
  end

  // edges only seen at machine cycle samples; reset to the idle levels
  // so that released lines do not raise a false edge after reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cond_prev_reg <= COND_IDLE;
    else if (mc_tick)
      cond_prev_reg <= cond;
  end

  always_comb
  begin
    rise = cond & ~cond_prev_reg;
    rise[4] = cond[4] ^ cond_prev_reg[4];
    if (!mc_tick)
      rise = 7'h00;
  end

  // type 0 is low level, type 1 is falling edge
  assign x0_set = mc_tick &&
    (timer_ctrl_reg[X0_SENSE_BIT] ? rise[0] : cond[0]);
  assign x1_set = mc_tick &&
    (timer_ctrl_reg[X1_SENSE_BIT] ? rise[1] : cond[1]);

  // ----------------------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------------------
  // timer control: write first, then clear on call, set wins over both
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timer_ctrl_reg <= REG_RESET;
    else
    begin
      if (sfr_we && sfr_addr == ADDR_TIMER_CTRL)
        timer_ctrl_reg <= sfr_wdata;
      if (ack_vec[SRC_TIM1])
        timer_ctrl_reg[T1_FLAG_BIT] <= 1'b0;
      if (ack_vec[SRC_TIM0])
        timer_ctrl_reg[T0_FLAG_BIT] <= 1'b0;
      if (ack_vec[SRC_EXT1])
        timer_ctrl_reg[X1_FLAG_BIT] <= 1'b0;
      if (ack_vec[SRC_EXT0])
        timer_ctrl_reg[X0_FLAG_BIT] <= 1'b0;
      if (timer1_ovf)
        timer_ctrl_reg[T1_FLAG_BIT] <= 1'b1;
      if (timer0_ovf)
        timer_ctrl_reg[T0_FLAG_BIT] <= 1'b1;
      if (x1_set)
        timer_ctrl_reg[X1_FLAG_BIT] <= 1'b1;
      if (x0_set)
        timer_ctrl_reg[X0_FLAG_BIT] <= 1'b1;
    end
  end

  // peripheral source flags, bits 1..5 for sources 2..6
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ext_req_reg <= REG_RESET;
    else
    begin
      if (sfr_we && sfr_addr == ADDR_EXT_REQ)
        ext_req_reg <= sfr_wdata & EXT_REQ_MASK;
      for (int k = 0; k < 5; k++)
      begin
        if (ack_vec[int'(SRC_EXT2) + k])
          ext_req_reg[k+1] <= 1'b0;
        if (rise[k+2])
          ext_req_reg[k+1] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  // enables, polarities and priorities all clear at reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      primary_en_reg <= REG_RESET;
      periph_en_reg <= REG_RESET;
      ser1_en_reg <= REG_RESET;
      edge_pol_reg <= REG_RESET;
      prio_low_reg <= REG_RESET;
      prio_high_reg <= REG_RESET;
    end
    else if (sfr_we)
    begin
      if (sfr_addr == ADDR_PRI_EN)
        primary_en_reg <= sfr_wdata & PRI_EN_MASK;
      else if (sfr_addr == ADDR_PERIPH_EN)
        periph_en_reg <= sfr_wdata & PERIPH_EN_MASK;
      else if (sfr_addr == ADDR_SER1_EN)
        ser1_en_reg <= sfr_wdata & SER1_EN_MASK;
      else if (sfr_addr == ADDR_EDGE_POL)
        edge_pol_reg <= sfr_wdata & EDGE_POL_MASK;
      else if (sfr_addr == ADDR_PRIO_LOW)
        prio_low_reg <= sfr_wdata & PRIO_MASK;
      else if (sfr_addr == ADDR_PRIO_HIGH)
        prio_high_reg <= sfr_wdata & PRIO_MASK;
    end
  end

  // registered read data, unmapped addresses read zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= REG_RESET;
    else if (sfr_re)
    begin
      if (sfr_addr == ADDR_TIMER_CTRL)
        rdata_reg <= timer_ctrl_reg;
      else if (sfr_addr == ADDR_PRI_EN)
        rdata_reg <= primary_en_reg;
      else if (sfr_addr == ADDR_PERIPH_EN)
        rdata_reg <= periph_en_reg;
      else if (sfr_addr == ADDR_SER1_EN)
        rdata_reg <= ser1_en_reg;
      else if (sfr_addr == ADDR_EDGE_POL)
        rdata_reg <= edge_pol_reg;
      else if (sfr_addr == ADDR_EXT_REQ)
        rdata_reg <= ext_req_reg;
      else if (sfr_addr == ADDR_PRIO_LOW)
        rdata_reg <= prio_low_reg;
      else if (sfr_addr == ADDR_PRIO_HIGH)
        rdata_reg <= prio_high_reg;
      else
        rdata_reg <= REG_RESET;
    end
  end

  // ----------------------------------------------------------------------
  // sampling and polling
  // ----------------------------------------------------------------------
  // source order follows src_t: the polling order within one level
  assign flags = {ext_req_reg[5:1], serial1_req, serial0_req,
    timer_ctrl_reg[T1_FLAG_BIT], timer_ctrl_reg[X1_FLAG_BIT],
    timer_ctrl_reg[T0_FLAG_BIT], timer_ctrl_reg[X0_FLAG_BIT]};
  assign enables = {periph_en_reg[5:1], ser1_en_reg[0],
    primary_en_reg[4:0]};
  assign global_en = primary_en_reg[GLOBAL_EN_BIT];

  // a called source's sample is dropped at once so it is not taken twice
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend_reg <= '0;
    else if (mc_tick)
      pend_reg <= flags & ~ack_vec;
    else
      pend_reg <= pend_reg & ~ack_vec;
  end

  // enables act on the sample immediately, not at the next tick
  assign eligible = global_en ? (pend_reg & enables) : '0;

  // group level from one bit of each priority register
  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
      src_lvl[i] = {prio_high_reg[group_of(4'(i))],
        prio_low_reg[group_of(4'(i))]};
  end

  // highest level wins, lowest index wins a tie
  always_comb
  begin
    win_valid = 1'b0;
    win_src = 4'h0;
    win_lvl = 2'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (eligible[i] && (!win_valid || src_lvl[i] >= win_lvl))
      begin
        win_valid = 1'b1;
        win_src = 4'(i);
        win_lvl = src_lvl[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // acknowledge
  // ----------------------------------------------------------------------
  // a write to any enable or priority register holds off the call
  assign blk_write = write_seen_reg || (sfr_we &&
    (sfr_addr == ADDR_PRI_EN || sfr_addr == ADDR_PERIPH_EN ||
    sfr_addr == ADDR_SER1_EN || sfr_addr == ADDR_PRIO_LOW ||
    sfr_addr == ADDR_PRIO_HIGH));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      write_seen_reg <= 1'b0;
    else if (insn_end)
      write_seen_reg <= 1'b0;
    else if (blk_write)
      write_seen_reg <= 1'b1;
  end

  // any active level at or above the winner blocks it
  assign nest_ok = (in_service_reg >> win_lvl) == 4'h0;
  assign take = insn_end && win_valid && nest_ok && !insn_is_reti &&
    !blk_write;
  assign ack_vec = take ? NUM_SRC'(1 << win_src) : '0;

  // highest set bit, the top active level, for ending service
  always_comb
  begin
    top_mask = 4'h0;
    for (int l = 0; l < NUM_LEVEL; l++)
      if (in_service_reg[l])
        top_mask = 4'(1 << l);
  end

  // one bit per level in service; return clears the highest
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      in_service_reg <= 4'h0;
    else if (take)
      in_service_reg <= in_service_reg | 4'(1 << win_lvl);
    else if (insn_end && insn_is_reti)
      in_service_reg <= in_service_reg & ~top_mask;
  end

  // forced call goes out one clock after the instruction ends
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      call_reg <= 1'b0;
      vector_reg <= 16'h0000;
      source_reg <= 4'h0;
      t0_ack_reg <= 1'b0;
      t1_ack_reg <= 1'b0;
    end
    else
    begin
      call_reg <= take;
      t0_ack_reg <= ack_vec[SRC_TIM0];
      t1_ack_reg <= ack_vec[SRC_TIM1];
      if (take)
      begin
        vector_reg <= vector_of(win_src);
        source_reg <= win_src;
      end
    end
  end

  assign sfr_rdata = rdata_reg;
  assign call_req = call_reg;
  assign call_vector = vector_reg;
  assign call_source = source_reg;
  assign timer0_ack = t0_ack_reg;
  assign timer1_ack = t1_ack_reg;
  assign service_active = in_service_reg;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_global_block;
    @(posedge clk) disable iff (rst)
    call_req |-> $past(global_en);
  endproperty
  a_global_block: assert property (p_global_block)
    else $error("call issued with global enable clear");

  property p_reti_block;
    @(posedge clk) disable iff (rst)
    insn_end && insn_is_reti |=> !call_req;
  endproperty
  a_reti_block: assert property (p_reti_block)
    else $error("call issued after return instruction");

  property p_write_block;
    @(posedge clk) disable iff (rst)
    insn_end && sfr_we && sfr_addr == ADDR_PRIO_HIGH |=> !call_req;
  endproperty
  a_write_block: assert property (p_write_block)
    else $error("call issued in priority write instruction");

  property p_nesting;
    @(posedge clk) disable iff (rst)
    call_req |-> ($past(in_service_reg) >> $past(win_lvl)) == 4'h0;
  endproperty
  a_nesting: assert property (p_nesting)
    else $error("call preempted equal or higher service");

  property p_vector;
    @(posedge clk) disable iff (rst)
    call_req |-> call_vector == vector_of(call_source) &&
      call_source == $past(win_src);
  endproperty
  a_vector: assert property (p_vector)
    else $error("call vector does not match source");

  property p_timer0_clear;
    @(posedge clk) disable iff (rst)
    timer0_ack |-> !timer_ctrl_reg[T0_FLAG_BIT] || $past(timer0_ovf);
  endproperty
  a_timer0_clear: assert property (p_timer0_clear)
    else $error("timer 0 flag not cleared on call");

  property p_flag_unmasked;
    @(posedge clk) disable iff (rst)
    timer1_ovf |=> timer_ctrl_reg[T1_FLAG_BIT];
  endproperty
  a_flag_unmasked: assert property (p_flag_unmasked)
    else $error("timer 1 overflow did not set flag");

  property p_sample_once;
    @(posedge clk) disable iff (rst)
    !mc_tick && !take |=> pend_reg == $past(pend_reg);
  endproperty
  a_sample_once: assert property (p_sample_once)
    else $error("samples changed between machine cycles");

  property p_service_end;
    @(posedge clk) disable iff (rst)
    insn_end && insn_is_reti && in_service_reg != 4'h0 |=>
      $countones(in_service_reg) == $countones($past(in_service_reg)) - 1;
  endproperty
  a_service_end: assert property (p_service_end)
    else $error("return did not end one service level");

  c_call: cover property (@(posedge clk) disable iff (rst) call_req);
  c_nested: cover property (@(posedge clk) disable iff (rst)
    call_req && $countones(service_active) == 2);
  c_ext2_set: cover property (@(posedge clk) disable iff (rst)
    $rose(ext_req_reg[1]));
  c_return: cover property (@(posedge clk) disable iff (rst)
    insn_end && insn_is_reti && service_active != 4'h0);

endmodule

// File: irq_pkg.sv
// Purpose: shared constants and types of the interrupt request controller
// Assumes: 8-bit special function register bus, 11 sources, 4 levels
// Notes: register offsets are byte addresses on the core's register bus
package irq_pkg;

  // ----------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;
  localparam logic [7:0] ADDR_SER1_EN = 8'h9A;
  localparam logic [7:0] ADDR_PRI_EN = 8'hA8;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'hA9;
  localparam logic [7:0] ADDR_PERIPH_EN = 8'hB8;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'hB9;
  localparam logic [7:0] ADDR_EXT_REQ = 8'hC0;
  localparam logic [7:0] ADDR_EDGE_POL = 8'hC8;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int GLOBAL_EN_BIT = 7;
  localparam int T1_FLAG_BIT = 7;
  localparam int T0_FLAG_BIT = 5;
  localparam int X1_FLAG_BIT = 3;
  localparam int X1_SENSE_BIT = 2;
  localparam int X0_FLAG_BIT = 1;
  localparam int X0_SENSE_BIT = 0;
  localparam int SRC3_POL_BIT = 6;
  localparam int SRC2_POL_BIT = 5;
  localparam logic [7:0] REG_RESET = 8'h00;
  // idle level of each conditioned source line, so reset gives no edge
  localparam logic [6:0] COND_IDLE = 7'h6C;
  localparam logic [7:0] PRI_EN_MASK = 8'hDF;
  localparam logic [7:0] PERIPH_EN_MASK = 8'h3E;
  localparam logic [7:0] SER1_EN_MASK = 8'h01;
  localparam logic [7:0] EXT_REQ_MASK = 8'h3E;
  localparam logic [7:0] EDGE_POL_MASK = 8'h60;
  localparam logic [7:0] PRIO_MASK = 8'h3F;

  // ----------------------------------------------------------------------
  // sources, groups, levels, vectors
  // ----------------------------------------------------------------------
  localparam int NUM_SRC = 11;
  localparam int NUM_LEVEL = 4;
  typedef enum logic [3:0] {
    SRC_EXT0, SRC_TIM0, SRC_EXT1, SRC_TIM1, SRC_SER0, SRC_SER1,
    SRC_EXT2, SRC_EXT3, SRC_EXT4, SRC_EXT5, SRC_EXT6
  } src_t;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam logic [15:0] VECTOR_STRIDE = 16'h0008;

  // priority group that a source shares its level with
  function automatic logic [2:0] group_of(input logic [3:0] s);
    case (s)
      4'h0, 4'h5: group_of = 3'h0;
      4'h1, 4'h6: group_of = 3'h1;
      4'h2, 4'h7: group_of = 3'h2;
      4'h3, 4'h8: group_of = 3'h3;
      4'h4, 4'h9: group_of = 3'h4;
      default: group_of = 3'h5;
    endcase
  endfunction

  function automatic logic [15:0] vector_of(input logic [3:0] s);
    vector_of = 16'(VECTOR_BASE + VECTOR_STRIDE * {12'h000, s});
  endfunction

  // request lines from on-chip peripheral logic
  typedef struct packed {
    logic transfer_pending;
    logic clock_one_second_tick;
    logic watchdog_near_overflow;
    logic eeprom_busy;
    logic pll_lock;
    logic compute_busy;
    logic flash_collision_a;
    logic flash_collision_b;
    logic spi_req;
  } periph_req_t;

endpackage

// File: core_seq_model.sv
// Purpose: core sequencer stand-in making machine and instruction strobes
// Assumes: two clocks per machine cycle, two machine cycles per instruction
// Notes: a return is issued on request at the next instruction end
`timescale 1ns/10ps
module core_seq_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the bench
  input wire logic reti_req,
  // strobes to the controller
  output logic mc_tick,
  output logic insn_end,
  output logic insn_is_reti
);
  logic [1:0] phase_reg;

  // ----------------------------------------------------------------
  // instruction timing
  // ----------------------------------------------------------------
  // falling edge, so strobes are settled well before the sampling edge
  always_ff @(negedge clk or posedge rst)
  begin
    if (rst)
      phase_reg <= 2'h0;
    else
      phase_reg <= phase_reg + 2'h1;
  end

  // one tick per machine cycle
  assign mc_tick = phase_reg[0];
  assign insn_end = (phase_reg == 2'h3);
  // only qualifies the closing clock, never a bare level
  assign insn_is_reti = insn_end & reti_req;
endmodule

// File: mpu_interrupt_controller_bench.sv
// Purpose: self-checking bench of the interrupt request controller
// Assumes: bench drives at the falling edge, design samples at rising
// Notes: serial requests are cleared by the bench after their call
`timescale 1ns/10ps
module mpu_interrupt_controller_bench
  import irq_pkg::*;
;
  logic clk, rst, sfr_we, sfr_re, mc_tick, insn_end, insn_is_reti;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, acc;
  logic call_req, timer0_ack, timer1_ack, reti_req;
  logic [15:0] call_vector;
  logic [3:0] call_source, service_active;
  logic ext0_pin_n, ext1_pin_n, timer0_ovf, timer1_ovf;
  logic serial0_req, serial1_req;
  periph_req_t periph;
  int bad_count, checks;
  logic [8:0] pat [5] = '{9'h001, 9'h008, 9'h010, 9'h020, 9'h080};
  logic [7:0] ra [6] = '{8'hA8, 8'hB8, 8'h9A, 8'hC8, 8'hA9, 8'hB9};
  logic [7:0] rm [6] = '{8'hDF, 8'h3E, 8'h01, 8'h60, 8'h3F, 8'h3F};

  // ----------------------------------------------------------------
  // design and partner
  // ----------------------------------------------------------------
  irq_controller irq_controller_inst (.clk(clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
    .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .mc_tick(mc_tick),
    .insn_end(insn_end), .insn_is_reti(insn_is_reti),
    .call_req(call_req), .call_vector(call_vector),
    .call_source(call_source), .timer0_ack(timer0_ack),
    .timer1_ack(timer1_ack), .service_active(service_active),
    .ext0_pin_n(ext0_pin_n), .ext1_pin_n(ext1_pin_n),
    .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf),
    .serial0_req(serial0_req), .serial1_req(serial1_req),
    .periph(periph));
  core_seq_model core_seq_model_inst (.clk(clk), .rst(rst),
    .reti_req(reti_req), .mc_tick(mc_tick), .insn_end(insn_end),
    .insn_is_reti(insn_is_reti));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'b1;
    @(negedge clk);
    sfr_we = 1'b0;
  endtask

  // read data is registered, so it is taken one cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_re = 1'b1;
    @(negedge clk);
    sfr_re = 1'b0;
    @(negedge clk);
    check({8'h00, sfr_rdata}, {8'h00, exp});
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bounded wait, then source, vector, acks and levels in service
  task automatic wait_call(input logic [3:0] src, input logic [15:0] vec,
    input logic [1:0] ack, input logic [3:0] sa);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (call_req !== 1'b1 && n < 60);
    check({15'h0000, call_req}, 16'h0001);
    check({12'h000, call_source}, {12'h000, src});
    check(call_vector, vec);
    check({14'h0000, timer1_ack, timer0_ack}, {14'h0000, ack});
    check({12'h000, service_active}, {12'h000, sa});
    @(negedge clk);
  endtask

  task automatic no_call(input int cyc);
    int hits;
    hits = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      #1;
      if (call_req === 1'b1)
        hits++;
    end
    check(16'(hits), 16'h0000);
    @(negedge clk);
  endtask

  task automatic do_reti(input logic [3:0] sa);
    @(negedge clk);
    reti_req = 1'b1;
    do @(posedge clk); while (insn_end !== 1'b1);
    @(negedge clk);
    reti_req = 1'b0;
    check({12'h000, service_active}, {12'h000, sa});
  endtask

  task automatic summarize();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // cut a hang short, well past the expected run of some 350 cycles
  initial
  begin
    #(25 * 5000);
    bad_count++;
    summarize();
  end

  // main sequence
  initial
  begin
    {sfr_we, sfr_re, reti_req, timer0_ovf, timer1_ovf} = 5'h00;
    {serial0_req, serial1_req, sfr_addr, sfr_wdata} = 18'h00000;
    {ext0_pin_n, ext1_pin_n} = 2'h3;
    periph = periph_req_t'(9'h000);
    bad_count = 0;
    checks = 0;
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    rdc(8'h88, 8'h00);
    rdc(8'h55, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      rdc(ra[i], 8'h00);
      wr(ra[i], 8'hFF);
      rdc(ra[i], rm[i]);
      wr(ra[i], 8'h00);
    end
    $display("test registers done");
    timer0_ovf = 1'b1;
    timer1_ovf = 1'b1;
    idle(1);
    {timer0_ovf, timer1_ovf} = 2'h0;
    wr(8'hA8, 8'h0A);
    rdc(8'h88, 8'hA0);
    no_call(16);
    wr(8'hA8, 8'h82);
    wait_call(4'h1, 16'h000B, 2'h1, 4'h1);
    rdc(8'h88, 8'h80);
    do_reti(4'h0);
    wr(8'hA9, 8'h02);
    wr(8'hB9, 8'h02);
    wr(8'hA8, 8'h8A);
    wait_call(4'h3, 16'h001B, 2'h2, 4'h1);
    serial0_req = 1'b1;
    wr(8'hA8, 8'h9A);
    no_call(16);
    timer0_ovf = 1'b1;
    idle(1);
    timer0_ovf = 1'b0;
    wait_call(4'h1, 16'h000B, 2'h1, 4'h9);
    do_reti(4'h1);
    no_call(12);
    do_reti(4'h0);
    wait_call(4'h4, 16'h0023, 2'h0, 4'h1);
    serial0_req = 1'b0;
    do_reti(4'h0);
    serial1_req = 1'b1;
    wr(8'h9A, 8'h01);
    wait_call(4'h5, 16'h002B, 2'h0, 4'h1);
    serial1_req = 1'b0;
    do_reti(4'h0);
    $display("test priority done");
    wr(8'hA8, 8'h00);
    ext0_pin_n = 1'b0;
    idle(8);
    rdc(8'h88, 8'h02);
    ext0_pin_n = 1'b1;
    idle(3);
    wr(8'h88, 8'h00);
    idle(8);
    rdc(8'h88, 8'h00);
    wr(8'h88, 8'h04);
    ext1_pin_n = 1'b0;
    idle(8);
    rdc(8'h88, 8'h0C);
    wr(8'hA8, 8'h84);
    wait_call(4'h2, 16'h0013, 2'h0, 4'h1);
    rdc(8'h88, 8'h04);
    do_reti(4'h0);
    ext1_pin_n = 1'b1;
    $display("test pins done");
    wr(8'hA8, 8'h00);
    wr(8'hC8, 8'h00);
    wr(8'hC0, 8'h00);
    acc = 8'h00;
    for (int i = 0; i < 5; i++)
    begin
      periph = periph_req_t'(pat[i]);
      idle(6);
      periph = periph_req_t'(9'h000);
      idle(6);
      acc = acc | (8'h02 << i);
      rdc(8'hC0, acc);
    end
    wr(8'hC8, 8'h20);
    wr(8'hC0, 8'h00);
    periph = periph_req_t'(9'h004);
    idle(6);
    rdc(8'hC0, 8'h02);
    wr(8'hB8, 8'h02);
    wr(8'hA8, 8'h80);
    wait_call(4'h6, 16'h0033, 2'h0, 4'h8);
    rdc(8'hC0, 8'h00);
    do_reti(4'h0);
    $display("test peripherals done");
    summarize();
  end
endmodule
